/* File: logic/spi_ctrl_pkg.sv */
// Constants, types and functions shared by the serial port control logic
// What this block does
// - Frame sync pulse precedes first bit clock, or meets it when sync-edge bit set
// - Enhanced bit selects two-word transmit buffer
// - Enhanced bit writable only while port off
// - Port runs only while enable bit set
// - Stop-in-idle halts port during idle mode
// - Output-disable releases serial data output pin
// - Audio widths: 24/32/16 data, channel 32/16
// - Plain mode: upper bit 32-bit, both zero 8-bit
// - Master samples at end or middle
// - Slave always samples at middle
// - Clock-edge bit picks data change edge outside framed mode
// - Slave-select pin used only when enabled
// - Audio mode forces idle-high clock
package spi_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_DATA = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_BAUD = 4'hC;
  localparam int B_FSE = 17;
  localparam int B_ENH = 16;
  localparam int B_ON = 15;
  localparam int B_HALT = 13;
  localparam int B_DOD = 12;
  localparam int B_WU = 11;
  localparam int B_WL = 10;
  localparam int B_PHASE = 9;
  localparam int B_CKE = 8;
  localparam int B_SEL_EN = 7;
  localparam int B_CPOL = 6;
  localparam int B_MST = 5;
  localparam int B_FRM = 4;
  localparam int B_AUD = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0003_BFF8;
  localparam logic [15:0] BAUD_RST = 16'h0004;
  localparam int S_BUSY = 0;
  localparam int S_TXFULL = 1;
  localparam int S_RXFULL = 2;
  localparam int S_RXOVF = 3;
  localparam int S_CHAN = 4;
  localparam int S_TXCNT = 5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b11
  } eng_state_t;

  // Bits per channel on the wire
  function automatic logic [5:0] chan_bits(input logic aud, input logic up, input logic lo);
    if (aud) begin
      chan_bits = up ? 6'h20 : 6'h10;
    end else if (up) begin
      chan_bits = 6'h20;
    end else begin
      chan_bits = lo ? 6'h10 : 6'h08;
    end
  endfunction

  // Payload bits inside a channel
  function automatic logic [5:0] data_bits(input logic aud, input logic up, input logic lo);
    if (aud && up && lo) begin
      data_bits = 6'h18;
    end else begin
      data_bits = chan_bits(aud, up, lo);
    end
  endfunction
endpackage

/* File: logic/spi_shift_engine.sv */
// Serial shift engine for master and slave transfers
`timescale 1ns/1ps
module spi_shift_engine
  import spi_ctrl_pkg::*;
(
  input wire logic sys_clk_i, // System clock
  input wire logic nrst_i, // Sync reset, active low
  input wire logic on_i, // Port enabled
  input wire logic hold_i, // Freeze while idle-stopped
  input wire logic start_i, // Load word and begin
  input wire logic master_i, // Master mode
  input wire logic cpol_i, // Effective idle clock level
  input wire logic cke_i, // Effective clock edge select
  input wire logic phase_i, // Effective sample phase
  input wire logic framed_i, // Framed mode
  input wire logic fs_edge_i, // Frame sync edge select
  input wire logic [5:0] nbits_i, // Bits per channel
  input wire logic [31:0] tx_i, // Left-aligned word
  input wire logic half_tick_i, // Master half bit enable
  input wire logic sck_lvl_i, // Filtered clock pin level
  input wire logic sck_edge_i, // Filtered clock pin change
  input wire logic ss_act_i, // Slave selected
  input wire logic sdi_i, // Filtered data input
  output logic sck_o, // Master clock out
  output logic sdo_o, // Serial data out
  output logic fs_o, // Frame sync pulse
  output logic busy_o, // Transfer in progress
  output logic done_o, // Word complete pulse
  output logic [31:0] rx_o // Received bits, right-aligned
);
  typedef struct packed {
    eng_state_t st;
    logic sck;
    logic fs;
    logic first;
    logic done;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [31:0] rx;
  } eng_t;

  eng_t r;
  eng_t nxt;
  logic ev;
  logic lead;
  logic trail;
  logic chg;
  logic smpl;

  always_comb begin
    nxt = r;
    nxt.done = 1'b0;
    ev = !hold_i && (master_i ? (half_tick_i && r.st != ST_IDLE) : sck_edge_i);
    lead = ev && (master_i ? (r.sck == cpol_i) : (sck_lvl_i != cpol_i));
    trail = ev && !lead;
    chg = cke_i ? trail : lead;
    smpl = phase_i ? chg : (ev && !chg);
    if (master_i && ev) begin
      nxt.sck = !r.sck;
    end
    case (r.st)
      ST_IDLE: begin
        nxt.sck = cpol_i;
        nxt.fs = 1'b0;
        if (start_i && !hold_i) begin
          nxt.sh = tx_i;
          nxt.cnt = 6'h00;
          nxt.first = 1'b1;
          if (master_i && framed_i && !fs_edge_i) begin
            nxt.st = ST_LEAD;
            nxt.fs = 1'b1;
          end else begin
            nxt.st = ST_SHIFT;
            nxt.fs = master_i && framed_i;
          end
        end
      end
      ST_LEAD: begin
        if (trail) begin
          nxt.st = ST_SHIFT;
          nxt.fs = 1'b0;
        end
      end
      ST_SHIFT: begin
        if (smpl) begin
          nxt.rx = {r.rx[30:0], sdi_i};
          nxt.cnt = 6'(r.cnt + 6'h01);
        end
        if (chg) begin
          if (!(r.first && !cke_i)) begin
            nxt.sh = {r.sh[30:0], 1'b0};
          end
          nxt.first = 1'b0;
        end
        if (trail) begin
          nxt.fs = 1'b0;
        end
        if (trail && nxt.cnt == nbits_i) begin
          nxt.st = ST_IDLE;
          nxt.done = 1'b1;
        end
        if (!master_i && !ss_act_i) begin
          nxt.st = ST_IDLE;
        end
      end
      default: begin
        nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !on_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign sck_o = r.sck;
  assign sdo_o = r.sh[31];
  assign fs_o = r.fs;
  assign busy_o = (r.st != ST_IDLE);
  assign done_o = r.done;
  assign rx_o = r.rx;
endmodule

/* File: logic/spi_control_config.sv */
// Serial port with control register, Wishbone slave and pin control
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module spi_control_config
  import spi_ctrl_pkg::*;
#(
  parameter int DIV_W = 16,
  parameter logic [15:0] BAUD_DEFAULT = BAUD_RST
)(
  input wire logic sys_clk_i, // System clock
  input wire logic nrst_i, // Sync reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [ADDR_W-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic idle_mode_i, // Device in idle mode
  input wire logic sck_i, // Clock pin in
  output logic sck_o, // Clock pin out
  output logic sck_oe_o, // Clock pin drive
  input wire logic sdi_i, // Data input pin
  output logic sdo_o, // Data output pin
  output logic sdo_oe_o, // Data output drive
  input wire logic ss_i, // Select pin in
  output logic ss_o, // Select/sync pin out
  output logic ss_oe_o // Select pin drive
);
  generate
    if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div
      $error("DIV_W must be 2..16");
    end
  endgenerate

  typedef struct packed {
    logic [31:0] ctrl;
    logic [DIV_W-1:0] baud;
    logic [DIV_W-1:0] div;
    logic tick;
    logic [31:0] tx0;
    logic [31:0] tx1;
    logic [1:0] txcnt;
    logic [31:0] rxd;
    logic rxfull;
    logic rxovf;
    logic chan;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] sck_s;
    logic [2:0] ss_s;
    logic [2:0] sdi_s;
    logic sck_f;
    logic ss_f;
    logic sdi_f;
    logic sck_edge;
  } top_t;

  top_t r;
  top_t nxt;

  logic on;
  logic mst;
  logic frm;
  logic aud;
  logic enh;
  logic hold;
  logic cpol_eff;
  logic cke_eff;
  logic phase_eff;
  logic ss_act;
  logic [5:0] nbits;
  logic [5:0] dbits;
  logic [1:0] cap;
  logic start;
  logic req;
  logic wr;
  logic rd;
  logic [31:0] txw;
  logic eng_sck;
  logic eng_sdo;
  logic eng_fs;
  logic eng_busy;
  logic eng_done;
  logic [31:0] eng_rx;
  logic [1:0] cnt_after_pop;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Received channel to right-aligned payload
  function automatic logic [31:0] rx_payload(input logic [31:0] raw, input logic [5:0] cb,
                                             input logic [5:0] db);
    logic [31:0] val;
    logic [31:0] msk;
    val = raw >> (cb - db);
    msk = (db == 6'h20) ? 32'hFFFF_FFFF : ((32'h0000_0001 << db) - 32'h0000_0001);
    return val & msk;
  endfunction

  // Effective configuration
  always_comb begin
    on = r.ctrl[B_ON];
    mst = r.ctrl[B_MST];
    frm = r.ctrl[B_FRM];
    aud = r.ctrl[B_AUD];
    enh = r.ctrl[B_ENH];
    hold = r.ctrl[B_HALT] && idle_mode_i;
    cpol_eff = r.ctrl[B_CPOL] || aud;
    cke_eff = r.ctrl[B_CKE] && !frm;
    phase_eff = r.ctrl[B_PHASE] && mst;
    ss_act = r.ctrl[B_SEL_EN] ? !r.ss_f : 1'b1;
    nbits = chan_bits(aud, r.ctrl[B_WU], r.ctrl[B_WL]);
    dbits = data_bits(aud, r.ctrl[B_WU], r.ctrl[B_WL]);
    cap = enh ? 2'h2 : 2'h1;
    txw = r.tx0 << (6'h20 - dbits);
    start = on && !hold && !eng_busy && (r.txcnt != 2'h0) && (mst || ss_act);
    cnt_after_pop = start ? 2'(r.txcnt - 2'h1) : r.txcnt;
    req = wb_cyc_i && wb_stb_i && !r.ack;
    wr = req && wb_we_i;
    rd = req && !wb_we_i;
  end

  always_comb begin
    nxt = r;
    nxt.ack = req;
    // Pin synchronisers and agreement filters
    nxt.sck_s = {r.sck_s[1:0], sck_i};
    nxt.ss_s = {r.ss_s[1:0], ss_i};
    nxt.sdi_s = {r.sdi_s[1:0], sdi_i};
    if (r.sck_s[1] == r.sck_s[2]) begin
      nxt.sck_f = r.sck_s[1];
    end
    if (r.ss_s[1] == r.ss_s[2]) begin
      nxt.ss_f = r.ss_s[1];
    end
    if (r.sdi_s[1] == r.sdi_s[2]) begin
      nxt.sdi_f = r.sdi_s[1];
    end
    nxt.sck_edge = (nxt.sck_f != r.sck_f);
    // Master half-bit divider
    nxt.tick = 1'b0;
    if (!on || !eng_busy || hold) begin
      nxt.div = '0;
    end else if (r.div >= r.baud) begin
      nxt.div = '0;
      nxt.tick = 1'b1;
    end else begin
      nxt.div = DIV_W'(r.div + 1'b1);
    end
    // Transmit buffer pop
    if (start) begin
      nxt.tx0 = r.tx1;
      nxt.txcnt = cnt_after_pop;
    end
    // Word received
    if (eng_done) begin
      nxt.rxd = rx_payload(eng_rx, nbits, dbits);
      nxt.chan = aud ? !r.chan : 1'b0;
    end
    // Register reads
    if (rd) begin
      case (wb_adr_i)
        OFS_CTRL: nxt.rdat = r.ctrl;
        OFS_DATA: nxt.rdat = r.rxd;
        OFS_STAT: begin
          nxt.rdat = 32'h0000_0000;
          nxt.rdat[S_BUSY] = eng_busy;
          nxt.rdat[S_TXFULL] = (r.txcnt >= cap);
          nxt.rdat[S_RXFULL] = r.rxfull;
          nxt.rdat[S_RXOVF] = r.rxovf;
          nxt.rdat[S_CHAN] = r.chan;
          nxt.rdat[S_TXCNT +: 2] = r.txcnt;
        end
        OFS_BAUD: nxt.rdat = 32'(r.baud);
        default: nxt.rdat = 32'h0000_0000;
      endcase
    end
    // Receive flags, set wins over clear
    if (rd && wb_adr_i == OFS_DATA) begin
      nxt.rxfull = 1'b0;
    end
    if (wr && wb_adr_i == OFS_STAT && wb_sel_i[0] && wb_dat_i[S_RXOVF]) begin
      nxt.rxovf = 1'b0;
    end
    if (eng_done) begin
      if (r.rxfull && !(rd && wb_adr_i == OFS_DATA)) begin
        nxt.rxovf = 1'b1;
      end
      nxt.rxfull = 1'b1;
    end
    // Register writes
    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          nxt.ctrl = merge(r.ctrl, wb_dat_i, wb_sel_i) & CTRL_WMASK;
          if (on) begin
            nxt.ctrl[B_ENH] = r.ctrl[B_ENH];
          end
          if (!r.ctrl[B_MST]) begin
            nxt.ctrl[B_PHASE] = 1'b0;
          end
          if (!nxt.ctrl[B_ON]) begin
            nxt.txcnt = 2'h0;
            nxt.chan = 1'b0;
          end
        end
        OFS_DATA: begin
          if (on && cnt_after_pop < cap) begin
            if (cnt_after_pop == 2'h0) begin
              nxt.tx0 = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
            end else begin
              nxt.tx1 = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
            end
            nxt.txcnt = 2'(cnt_after_pop + 2'h1);
          end
        end
        OFS_BAUD: nxt.baud = DIV_W'(merge(32'(r.baud), wb_dat_i, wb_sel_i));
        default: nxt.baud = r.baud;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.baud <= DIV_W'(BAUD_DEFAULT);
      // Select pin idles high; no false select after reset
      r.ss_s <= 3'h7;
      r.ss_f <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  spi_shift_engine u_eng (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .on_i(on),
    .hold_i(hold),
    .start_i(start),
    .master_i(mst),
    .cpol_i(cpol_eff),
    .cke_i(cke_eff),
    .phase_i(phase_eff),
    .framed_i(frm),
    .fs_edge_i(r.ctrl[B_FSE]),
    .nbits_i(nbits),
    .tx_i(txw),
    .half_tick_i(r.tick),
    .sck_lvl_i(r.sck_f),
    .sck_edge_i(r.sck_edge),
    .ss_act_i(ss_act),
    .sdi_i(r.sdi_f),
    .sck_o(eng_sck),
    .sdo_o(eng_sdo),
    .fs_o(eng_fs),
    .busy_o(eng_busy),
    .done_o(eng_done),
    .rx_o(eng_rx)
  );

  // Pin drive
  always_comb begin
    sck_o = eng_sck;
    sck_oe_o = on && mst;
    sdo_o = eng_sdo;
    sdo_oe_o = on && !r.ctrl[B_DOD];
    ss_oe_o = on && mst;
    if (aud) begin
      ss_o = r.chan;
    end else if (frm) begin
      ss_o = eng_fs;
    end else begin
      ss_o = !eng_busy;
    end
  end

  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
endmodule

/* File: tb/spi_control_config_sva.sv */
// Checker for the serial port pins and register bus
`timescale 1ns/1ps
module spi_control_config_sva
  import spi_ctrl_pkg::*;
(
  input wire logic sys_clk_i, // clock
  input wire logic nrst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [ADDR_W-1:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic wb_ack_o, // ack
  input wire logic idle_mode_i, // idle
  input wire logic sck_o, // clock out
  input wire logic sck_oe_o, // clock drive
  input wire logic sdo_o, // data out
  input wire logic sdo_oe_o, // data drive
  input wire logic ss_o, // select out
  input wire logic ss_oe_o // select drive
);
  logic [31:0] c_r;
  // Copy of control bits, taken with the write
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      c_r <= '0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL) begin
      c_r <= wb_dat_i;
    end
  end
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  sdo_drive_a: assert property (sdo_oe_o == (c_r[B_ON] && !c_r[B_DOD])) else $error("data pin drive");
  clk_drive_a: assert property (sck_oe_o == (c_r[B_ON] && c_r[B_MST]) && ss_oe_o == sck_oe_o)
    else $error("clock pin drive");
  off_still_a: assert property ((!c_r[B_ON])[*4] |-> $stable(sck_o) && $stable(sdo_o))
    else $error("pins move while off");
  idle_freeze_a: assert property ((c_r[B_ON] && c_r[B_HALT] && idle_mode_i)[*3]
    |-> $stable(sck_o) && $stable(sdo_o)) else $error("runs during idle");
  idle_level_a: assert property ((c_r[B_ON] && c_r[B_MST] && !c_r[B_FRM] && !c_r[B_AUD] && ss_o && $stable(c_r))[*4]
    |-> sck_o == c_r[B_CPOL]) else $error("idle clock level");
  data_edge_a: assert property (c_r[B_ON] && c_r[B_MST] && c_r[B_CKE] && !c_r[B_FRM] && !c_r[B_AUD] && !ss_o
    && $past(!ss_o) && $changed(sdo_o) |-> $changed(sck_o) && sck_o == c_r[B_CPOL]) else $error("data edge");
endmodule
bind spi_control_config spi_control_config_sva spi_control_config_sva_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .idle_mode_i(idle_mode_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o), .ss_o(ss_o), .ss_oe_o(ss_oe_o));

/* File: tb/spi_far_end.sv */
// Far-end serial device model
`timescale 1ns/1ps
module spi_far_end (
  input wire logic sck_i, // clock from port
  input wire logic sel_n_i, // select from port
  input wire logic link_run_i, // run link clock
  output logic miso_o, // data to port
  output logic link_clk_o, // link clock
  output int edges_o // clock edges seen
);
  initial begin
    miso_o = 1'b0;
    link_clk_o = 1'b0;
    edges_o = 0;
  end
  // Every edge counts; new bit while selected
  always @(sck_i) begin
    edges_o <= edges_o + 1;
    if (!sel_n_i) begin
      miso_o <= ~miso_o;
    end
  end
  // Released line does not keep its last bit
  always @(posedge sel_n_i) begin
    miso_o <= ~miso_o;
  end
  // Link clock stands still between frames
  always begin
    #62.5;
    link_clk_o = link_run_i ? ~link_clk_o : 1'b0;
  end
endmodule

/* File: tb/test_spi_control_config.sv */
// Testbench for the serial port control block
`timescale 1ns/1ps
module test_spi_control_config;
  import spi_ctrl_pkg::*;
  typedef struct {logic [31:0] m; logic [31:0] v;} note_t;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr;
  logic ack;
  logic idle = 1'b0;
  logic link_run = 1'b0;
  logic sel_n = 1'b1;
  logic miso, lclk, sck, sck_oe, sdo, sdo_oe, ss, ss_oe;
  int edges;
  note_t notes[$];
  note_t nt;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] rd;
  int e0;
  int k;

  spi_control_config spi_control_config_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .idle_mode_i(idle),
    .sck_i(lclk), .sck_o(sck), .sck_oe_o(sck_oe), .sdi_i(miso), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .ss_i(sel_n),
    .ss_o(ss), .ss_oe_o(ss_oe));
  spi_far_end spi_far_end_i (.sck_i(sck), .sel_n_i(ss), .link_run_i(link_run), .miso_o(miso), .link_clk_o(lclk),
    .edges_o(edges));

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic bad(input string s);
    errors++;
    $display("Error at %0t: %s", $time, s);
  endtask

  // Single bus cycle; notes what a read must show under mask m
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [31:0] v);
    int t;
    notes.push_back('{m, v});
    @(posedge sys_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    t = 0;
    do begin
      @(posedge sys_clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (t >= 50) begin
      bad("bus timeout");
      report_and_stop();
    end
  endtask

  // Reads are checked as their answers appear
  always @(posedge sys_clk_i) begin
    if (ack === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.m != 32'h0) begin
        n_compared++;
        if ((dr & nt.m) !== nt.v) begin
          bad("read data");
        end
      end
    end
  end

  // One word out with control c; optional idle stall mid-word
  task automatic xfer(input logic [31:0] c, input int n, input int stall);
    wb(1'b1, OFS_CTRL, c, 32'h0, 32'h0);
    // Let a new idle clock level settle before counting
    repeat (2) @(posedge sys_clk_i);
    e0 = edges;
    wb(1'b1, OFS_DATA, $urandom, 32'h0, 32'h0);
    if (stall > 0) begin
      repeat (10) @(posedge sys_clk_i);
      idle <= 1'b1;
      repeat (stall) @(posedge sys_clk_i);
      idle <= 1'b0;
    end
    k = 0;
    rd = 32'h1;
    while (rd[S_BUSY] !== 1'b0 && k < 400) begin
      wb(1'b0, OFS_STAT, 32'h0, 32'h0, 32'h0);
      k++;
    end
    n_compared++;
    if (k >= 400 || edges - e0 != n) begin
      bad("clock edge count");
    end
    wb(1'b0, OFS_DATA, 32'h0, 32'h0, 32'h0);
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    bad("run timeout");
    report_and_stop();
  end

  initial begin
    void'($urandom(29386));
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    wb(1'b0, OFS_CTRL, 32'h0, 32'hFFFF_FFFF, CTRL_RST);
    wb(1'b0, OFS_BAUD, 32'h0, 32'h0000_FFFF, {16'h0000, BAUD_RST});
    wb(1'b0, 4'h2, 32'h0, 32'hFFFF_FFFF, 32'h0);
    $display("done: reset values");
    wb(1'b1, OFS_CTRL, 32'h0000_8000, 32'h0, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h0001_8000, 32'h0, 32'h0);
    wb(1'b0, OFS_CTRL, 32'h0, 32'h0001_0000, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h0, 32'h0, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h0001_0000, 32'h0, 32'h0);
    wb(1'b0, OFS_CTRL, 32'h0, 32'h0001_0000, 32'h0001_0000);
    wb(1'b1, OFS_CTRL, 32'h0000_0200, 32'h0, 32'h0);
    wb(1'b0, OFS_CTRL, 32'h0, 32'h0000_0200, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h0000_0020, 32'h0, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h0000_0220, 32'h0, 32'h0);
    wb(1'b0, OFS_CTRL, 32'h0, 32'h0000_0200, 32'h0000_0200);
    $display("done: write guards");
    wb(1'b1, OFS_BAUD, 32'h1, 32'h0, 32'h0);
    for (int w = 0; w < 4; w++) begin
      xfer(32'h0000_8120 | (w << 10) | ((w & 1) << 6), w[1] ? 64 : (w[0] ? 32 : 16), 0);
    end
    $display("done: widths");
    xfer(32'h0000_B120, 16, 40);
    xfer(32'h0002_8030, 16, 0);
    xfer(32'h0000_8030, 18, 0);
    xfer(32'h0000_8320, 16, 0);
    xfer(32'h0000_8C28, 64, 0);
    $display("done: idle stop and framed");
    wb(1'b1, OFS_CTRL, 32'h0000_8080, 32'h0, 32'h0);
    wb(1'b1, OFS_DATA, $urandom, 32'h0, 32'h0);
    link_run <= 1'b1;
    repeat (100) @(posedge sys_clk_i);
    link_run <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    wb(1'b0, OFS_STAT, 32'h0, 32'h0000_0005, 32'h0);
    $display("done: unselected slave");
    sel_n <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    link_run <= 1'b1;
    repeat (200) @(posedge sys_clk_i);
    link_run <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    wb(1'b0, OFS_STAT, 32'h0, 32'h0000_0005, 32'h0000_0004);
    $display("done: selected slave");
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    wb(1'b0, OFS_CTRL, 32'h0, 32'hFFFF_FFFF, CTRL_RST);
    $display("done: second reset");
    report_and_stop();
  end
endmodule
